// File: testbench/sac_analog_model.sv
// Analog inputs behind the channel multiplexer, with comparator.
// Assumes one-hot routing and an ideal DAC on dac_code.
module sac_analog_model (
    input wire logic                                           sys_clk,    // Clock
    input wire logic [sac_pkg::CH_NUM-1:0]                     mux_select, // Routing
    input wire logic [sac_pkg::CH_NUM-1:0][sac_pkg::RES_W-1:0] level,      // Input levels
    input wire logic [sac_pkg::RES_W-1:0]                      dac_code,   // Trial code
    output logic                                               cmp_in      // Comparator
);
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;
    logic alt = 1'b0;
    // Floating comparator when nothing is routed
    always_ff @(posedge sys_clk) begin
        alt <= !alt;
    end
    // Compare routed input against trial code
    always_comb begin
        cmp_in = alt;
        for (int i = 0; i < CH_NUM; i++) begin
            if (mux_select[i]) begin
                cmp_in = level[i] >= dac_code;
            end
        end
    end
endmodule

// File: testbench/sac_asserts.sv
// Port checker for the SAR converter front end.
// Assumes binding onto sac_top, one clock domain.
module sac_asserts (
    input wire logic                       sys_clk,          // Clock
    input wire logic                       reset_n,          // Reset
    input wire logic                       hsel,             // Select
    input wire logic [sac_pkg::ADDR_W-1:0] haddr,            // Address
    input wire logic [1:0]                 htrans,           // Transfer
    input wire logic                       hwrite,           // Write
    input wire logic [2:0]                 hsize,            // Size
    input wire logic [31:0]                hwdata,           // Write data
    input wire logic                       hready,           // Ready in
    input wire logic [31:0]                hrdata,           // Read data
    input wire logic                       hreadyout,        // Ready out
    input wire logic                       hresp,            // Response
    input wire logic                       usb_token_active, // Token
    input wire logic                       cmp_in,           // Comparator
    input wire logic [sac_pkg::CH_NUM-1:0] mux_select,       // Mux
    input wire logic                       adc_enable,       // Enable
    input wire logic [sac_pkg::RES_W-1:0]  dac_code,         // Trial code
    input wire logic                       sample_hold,      // Track
    input wire logic                       irq               // Interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;
    logic req;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Accepted address phase
    assign req = hsel && htrans[1] && hready;
    property p_okay;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not OKAY");
    property p_onehot;
        $onehot0(mux_select);
    endproperty
    a_onehot: assert property (p_onehot) else $error("two inputs routed");
    property p_enable;
        mux_select != 15'h0000 |-> adc_enable;
    endproperty
    a_enable: assert property (p_enable) else $error("routed while off");
    property p_sample;
        sample_hold |-> adc_enable;
    endproperty
    a_sample: assert property (p_sample) else $error("sampling while off");
    property p_first_trial;
        $fell(sample_hold) |-> dac_code == 10'h200;
    endproperty
    a_first_trial: assert property (p_first_trial) else $error("first trial not MSB");
    property p_lo_read;
        req && !hwrite && haddr == ADDR_RES_LO |=> hrdata[5:0] == 6'h00 && hrdata[31:8] == 24'h0;
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("low result unused bits set");
    property p_hi_read;
        req && !hwrite && haddr == ADDR_RES_HI |=> hrdata[31:8] == 24'h0;
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("high result too wide");
    property p_sel_read;
        req && !hwrite && haddr == ADDR_SELECT |=> hrdata[5] == 1'b0 && hrdata[31:8] == 24'h0;
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select unused bit set");
    property p_unmapped;
        req && !hwrite && haddr == 8'h18 |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mask_off;
        req && hwrite && haddr == ADDR_IRQ_MSK ##1 hwdata[1:0] == 2'b00 |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
    c_conv: cover property ($fell(sample_hold));
    c_irq: cover property ($rose(irq));
    c_last: cover property (mux_select[14]);
endmodule

// File: testbench/sar_adc_control_tb.sv
// Self-checking bench for the SAR converter front end.
// Assumes sac_top as sole AHB-Lite slave and a 25 MHz clock.
module sar_adc_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sac_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic usb_token_active = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic hreadyout, hresp, cmp_in, adc_enable, sample_hold, irq;
    logic [CH_NUM-1:0] mux_select;
    logic [RES_W-1:0] dac_code;
    logic [CH_NUM-1:0][RES_W-1:0] level;
    int miscompares = 0, n_tests = 0, cyc = 0, n;
    sac_top sac_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .usb_token_active(usb_token_active),
        .cmp_in(cmp_in), .mux_select(mux_select), .adc_enable(adc_enable), .dac_code(dac_code),
        .sample_hold(sample_hold), .irq(irq));
    sac_analog_model sac_analog_model_i (.sys_clk(sys_clk), .mux_select(mux_select),
        .level(level), .dac_code(dac_code), .cmp_in(cmp_in));
    // Clock and cycle count
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer, read data into rd
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task start(input logic [4:0] s);
        bus(1'b1, ADDR_SELECT, {24'h0, 3'b100, s});
        repeat (4) @(posedge sys_clk);
        chk(mux_select, 32'h1 << (s - 5'd2));
    endtask
    // Poll go until hardware clears it, n = cycles taken
    task wait_done(input logic [4:0] s, input int t0);
        int k;
        k = 0;
        rd = 32'h80;
        while (rd[7] !== 1'b0 && k < 6000) begin
            bus(1'b0, ADDR_SELECT, 32'h0);
            k++;
        end
        n = cyc - t0;
        chk(rd[7:0], {3'b000, s});
    endtask
    task conv(input logic [4:0] s);
        int t0;
        t0 = cyc;
        start(s);
        wait_done(s, t0);
    endtask
    task t_reset;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(rd, 32'h0000_0000);
        end
        chk(irq, 1'b0);
        chk(adc_enable, 1'b0);
    endtask
    task t_channels;
        for (int s = 2; s <= 16; s++) begin
            conv(5'(s));
            bus(1'b0, ADDR_RES_HI, 32'h0);
            chk(rd, {24'h0, level[s-2][9:2]});
            bus(1'b0, ADDR_RES_LO, 32'h0);
            chk(rd, {24'h0, level[s-2][1:0], 6'h00});
        end
    endtask
    task t_rates;
        int d;
        for (int cs = 0; cs < 4; cs++) begin
            d = DIV_BASE << cs;
            bus(1'b1, ADDR_CONTROL, 32'(cs));
            bus(1'b0, ADDR_CONTROL, 32'h0);
            chk(rd, 32'(cs));
            conv(5'h05);
            chk(n >= 11 * d && n <= 13 * d, 1'b1);
        end
    endtask
    // Refused starts, and writes during a conversion
    task t_refuse;
        int t0;
        bus(1'b1, ADDR_CONTROL, 32'h0);
        bus(1'b1, ADDR_SELECT, 32'h80);
        bus(1'b0, ADDR_SELECT, 32'h0);
        chk(rd[7], 1'b0);
        chk(adc_enable, 1'b0);
        bus(1'b1, ADDR_SELECT, 32'h81);
        bus(1'b0, ADDR_SELECT, 32'h0);
        chk(rd[7], 1'b0);
        t0 = cyc;
        start(5'h03);
        repeat (300) @(posedge sys_clk);
        bus(1'b1, ADDR_SELECT, 32'h05);
        bus(1'b0, ADDR_RES_HI, 32'h0);
        chk(rd, {24'h0, level[3][9:2]});
        wait_done(5'h03, t0);
        bus(1'b0, ADDR_RES_HI, 32'h0);
        chk(rd, {24'h0, level[1][9:2]});
    endtask
    task t_irq;
        bus(1'b1, ADDR_IRQ_MSK, 32'h0);
        bus(1'b0, ADDR_IRQ_STS, 32'h0);
        chk(rd[0], 1'b1);
        chk(irq, 1'b0);
        bus(1'b1, ADDR_IRQ_MSK, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        bus(1'b1, ADDR_IRQ_STS, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        usb_token_active <= 1'b1;
        repeat (3) @(posedge sys_clk);
        bus(1'b0, ADDR_SELECT, 32'h0);
        chk(rd[6], 1'b1);
        bus(1'b1, ADDR_IRQ_MSK, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        usb_token_active <= 1'b0;
        bus(1'b0, ADDR_SELECT, 32'h0);
        chk(rd[6], 1'b0);
        bus(1'b1, ADDR_IRQ_STS, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
    endtask
    // Main sequence
    initial begin
        for (int i = 0; i < CH_NUM; i++) begin
            level[i] = 10'(i * 181 + 42);
        end
        level[0] = 10'h000;
        level[14] = 10'h3FF;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_channels();
        t_rates();
        t_refuse();
        t_irq();
        stop_test();
    end
    // Watchdog
    initial begin
        #2_400_000;
        miscompares++;
        stop_test();
    end
endmodule
bind sac_top sac_asserts sac_asserts_i (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .usb_token_active(usb_token_active), .cmp_in(cmp_in), .mux_select(mux_select),
    .adc_enable(adc_enable), .dac_code(dac_code), .sample_hold(sample_hold), .irq(irq));

// File: verilog/sac_pkg.sv
// Constants, register map and state encoding for the SAR converter control block.
// Assumes a single 25 MHz system clock and an AHB-Lite register bus with 32-bit data.
package sac_pkg;
    // Sizes
    localparam int RES_W   = 10;
    localparam int SEL_W   = 5;
    localparam int CH_NUM  = 15;
    localparam int CKSEL_W = 2;
    localparam int IRQ_W   = 2;
    localparam int ADDR_W  = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_SELECT  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RES_HI  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_RES_LO  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 8'h14;

    // Field positions
    localparam int GO_BIT    = 7;
    localparam int TOKEN_BIT = 6;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_TOKEN = 1;
    localparam int LO_SHIFT  = 6;

    // Selector codes
    localparam logic [SEL_W-1:0] SEL_DISABLE = 5'h00;
    localparam logic [SEL_W-1:0] SEL_FIRST   = 5'h02;
    localparam logic [SEL_W-1:0] SEL_LAST    = 5'h10;

    // Reset values
    localparam logic [SEL_W-1:0]   RST_SELECT  = 5'h00;
    localparam logic [7:0]         RST_RESULT  = 8'h00;
    localparam logic [CKSEL_W-1:0] RST_CKSEL   = 2'h0;
    localparam logic [IRQ_W-1:0]   RST_IRQ     = 2'h0;
    localparam logic [31:0]        RDATA_ZERO  = 32'h0000_0000;

    // Timing: fastest conversion clock, divided down by powers of two
    localparam int SYS_CLK_HZ      = 25_000_000;
    localparam int CONV_CLK_MAX_HZ = 256_000;
    localparam int DIV_BASE        = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
    localparam int DIV_W           = 10;
    localparam int CONV_TICKS      = 12;

    typedef enum logic [1:0] {
        SAC_IDLE    = 2'b00,
        SAC_SAMPLE  = 2'b01,
        SAC_CONVERT = 2'b10,
        SAC_STORE   = 2'b11
    } sac_state_t;
endpackage

// File: verilog/sac_sar_core.sv
// Successive-approximation engine, stepped by the conversion clock enable.
// Assumes the comparator level is already synchronised and the DAC settles in one tick.
module sac_sar_core (
    input  wire logic sys_clk,  // System clock
    input  wire logic reset_n,  // Asynchronous reset, active low
    sac_sar_if.core   sar       // Engine side of the link
);
    import sac_pkg::*;

    sac_state_t                 state;
    logic [$clog2(RES_W)-1:0]   bit_idx;

    // Sequencer: sample, ten trial bits, store
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= SAC_IDLE;
            bit_idx      <= '0;
            sar.dac_code <= '0;
            sar.sample   <= 1'b0;
            sar.busy     <= 1'b0;
        end else begin
            unique case (state)
                SAC_IDLE: begin
                    if (sar.start) begin
                        state        <= SAC_SAMPLE;
                        sar.sample   <= 1'b1;
                        sar.busy     <= 1'b1;
                        sar.dac_code <= '0;
                    end
                end
                SAC_SAMPLE: begin
                    if (sar.tick) begin
                        state        <= SAC_CONVERT;
                        sar.sample   <= 1'b0;
                        bit_idx      <= ($clog2(RES_W))'(RES_W - 1);
                        sar.dac_code <= {1'b1, {(RES_W-1){1'b0}}};
                    end
                end
                SAC_CONVERT: begin
                    if (sar.tick) begin
                        // Keep trial bit when input is at or above the DAC level
                        sar.dac_code[bit_idx] <= sar.cmp;
                        if (bit_idx != '0) begin
                            sar.dac_code[bit_idx - 1'b1] <= 1'b1;
                            bit_idx <= bit_idx - 1'b1;
                        end else begin
                            state <= SAC_STORE;
                        end
                    end
                end
                SAC_STORE: begin
                    if (sar.tick) begin
                        state    <= SAC_IDLE;
                        sar.busy <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Completion pulse and finished code
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sar.done   <= 1'b0;
            sar.result <= '0;
        end else begin
            sar.done <= (state == SAC_STORE) && sar.tick;
            if ((state == SAC_STORE) && sar.tick) begin
                sar.result <= sar.dac_code;
            end
        end
    end
endmodule

// File: verilog/sac_sar_if.sv
// Link between the register front end and the approximation engine.
// Assumes both ends run on the same system clock.
interface sac_sar_if;
    import sac_pkg::*;
    logic             start;    // One-cycle start request
    logic             tick;     // Conversion clock enable
    logic             cmp;      // Synchronised comparator level
    logic             busy;     // Engine running
    logic             done;     // One-cycle completion pulse
    logic [RES_W-1:0] result;   // Finished code
    logic [RES_W-1:0] dac_code; // Trial code to the DAC
    logic             sample;   // Track/hold control

    modport core (input start, tick, cmp, output busy, done, result, dac_code, sample);
    modport ctrl (output start, tick, cmp, input busy, done, result, dac_code, sample);
endinterface

// File: verilog/sac_top.sv
// Register front end of the SAR converter: AHB-Lite slave, channel multiplexer control,
// conversion clock divider, comparator synchroniser and interrupt logic.
// Assumes a 25 MHz system clock, an external comparator and a resistive DAC driven
// from dac_code, and a USB core on the same clock reporting transaction activity.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module sac_top (
    input  wire logic                          sys_clk,          // System clock
    input  wire logic                          reset_n,          // Async reset, active low
    input  wire logic                          hsel,             // Slave select
    input  wire logic [sac_pkg::ADDR_W-1:0]    haddr,            // Byte address
    input  wire logic [1:0]                    htrans,           // Transfer type
    input  wire logic                          hwrite,           // Write when high
    input  wire logic [2:0]                    hsize,            // Transfer size
    input  wire logic [31:0]                   hwdata,           // Write data
    input  wire logic                          hready,           // Bus ready
    output logic      [31:0]                   hrdata,           // Read data
    output logic                               hreadyout,        // Slave ready
    output logic                               hresp,            // Always OKAY
    input  wire logic                          usb_token_active, // USB transaction in progress
    input  wire logic                          cmp_in,           // Comparator pin, async
    output logic      [sac_pkg::CH_NUM-1:0]    mux_select,       // One-hot input select
    output logic                               adc_enable,       // Converter powered
    output logic      [sac_pkg::RES_W-1:0]     dac_code,         // Trial code to DAC
    output logic                               sample_hold,      // Track when high
    output logic                               irq               // Level interrupt
);
    import sac_pkg::*;

    sac_sar_if sar ();

    logic [SEL_W-1:0]   channel_selector_field;
    logic               go_flag;
    logic               token_flag;
    logic               token_q;
    logic [7:0]         adc_result_high;
    logic [7:0]         adc_result_low;
    logic               conv_clock_select_lo;
    logic               conv_clock_select_hi;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   next_irq_status;
    logic               wr_pend;
    logic [ADDR_W-1:0]  wr_addr;
    logic [31:0]        next_rdata;
    logic               addr_phase;
    logic               start_req;
    logic               sel_valid;
    logic [SEL_W-1:0]   active_sel;
    logic [SEL_W-1:0]   next_sel;
    logic [DIV_W-1:0]   div_cnt;
    logic [DIV_W-1:0]   div_reload;
    logic               tick_q;
    logic               cmp_meta;
    logic               cmp_sync;
    logic               token_rise;
    logic               wr_select;
    logic               wr_control;
    logic               wr_irq_sts;
    logic               wr_irq_msk;

    // Engine
    sac_sar_core sac_sar_core_i (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .sar     (sar)
    );

    assign sar.start   = start_req;
    assign sar.tick    = tick_q;
    assign sar.cmp     = cmp_sync;
    assign dac_code    = sar.dac_code;
    assign sample_hold = sar.sample;

    // Address phase qualifier and write decodes
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_select  = wr_pend && (wr_addr == ADDR_SELECT);
    assign wr_control = wr_pend && (wr_addr == ADDR_CONTROL);
    assign wr_irq_sts = wr_pend && (wr_addr == ADDR_IRQ_STS);
    assign wr_irq_msk = wr_pend && (wr_addr == ADDR_IRQ_MSK);

    // Only channels 2..16 carry an input
    assign sel_valid = (hwdata[SEL_W-1:0] >= SEL_FIRST)
                    && (hwdata[SEL_W-1:0] <= SEL_LAST);

    // Start on a 0 to 1 write of go with a valid channel
    assign start_req = wr_select && hwdata[GO_BIT] && !go_flag
                    && !sar.busy && sel_valid;

    assign token_rise = usb_token_active && !token_q;

    // Write address capture for the data phase
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else if (hready) begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr;
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        next_rdata = RDATA_ZERO;
        unique case (haddr)
            ADDR_SELECT: begin
                next_rdata[GO_BIT]      = go_flag;
                next_rdata[TOKEN_BIT]   = token_flag;
                next_rdata[SEL_W-1:0]   = channel_selector_field;
            end
            ADDR_RES_HI:  next_rdata[7:0] = adc_result_high;
            ADDR_RES_LO:  next_rdata[7:0] = adc_result_low;
            ADDR_CONTROL: next_rdata[CKSEL_W-1:0] = {conv_clock_select_hi,
                                                      conv_clock_select_lo};
            ADDR_IRQ_STS: next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQ_MSK: next_rdata[IRQ_W-1:0] = irq_mask;
            default:      next_rdata = RDATA_ZERO;
        endcase
    end

    // Read data for the following data phase
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= RDATA_ZERO;
        end else if (addr_phase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Channel selector; held while a conversion runs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_selector_field <= RST_SELECT;
        end else if (wr_select && !sar.busy && !go_flag) begin
            channel_selector_field <= hwdata[SEL_W-1:0];
        end
    end

    // Go flag: firmware sets, hardware clears on the edge the result registers load
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            go_flag <= 1'b0;
        end else if (start_req) begin
            go_flag <= 1'b1;
        end else if (sar.done) begin
            go_flag <= 1'b0;
        end
    end

    // Token bit follows USB activity
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            token_flag <= 1'b0;
            token_q    <= 1'b0;
        end else begin
            token_flag <= usb_token_active;
            token_q    <= usb_token_active;
        end
    end

    // Result registers, both loaded together at completion
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_result_high <= RST_RESULT;
            adc_result_low  <= RST_RESULT;
        end else if (sar.done) begin
            adc_result_high <= sar.result[RES_W-1:2];
            adc_result_low  <= {sar.result[1:0], 6'h00};
        end
    end

    // Conversion clock select
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {conv_clock_select_hi, conv_clock_select_lo} <= RST_CKSEL;
        end else if (wr_control) begin
            {conv_clock_select_hi, conv_clock_select_lo} <= hwdata[CKSEL_W-1:0];
        end
    end

    // Divider reload: base period doubled per select step
    assign div_reload = DIV_W'((DIV_BASE << {conv_clock_select_hi,
                                             conv_clock_select_lo}) - 1);

    // Conversion clock enable, restarted with each conversion
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            tick_q  <= 1'b0;
        end else if (start_req || !sar.busy) begin
            div_cnt <= div_reload;
            tick_q  <= 1'b0;
        end else if (div_cnt == '0) begin
            div_cnt <= div_reload;
            tick_q  <= 1'b1;
        end else begin
            div_cnt <= div_cnt - 1'b1;
            tick_q  <= 1'b0;
        end
    end

    // Comparator pin synchroniser
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= cmp_in;
            cmp_sync <= cmp_meta;
        end
    end

    // Next routed channel: start value, idle selector, or held while converting
    always_comb begin
        next_sel = active_sel;
        if (start_req) begin
            next_sel = hwdata[SEL_W-1:0];
        end else if (!sar.busy && !go_flag) begin
            next_sel = channel_selector_field;
        end
    end

    // Channel and enable move on one edge, so no input stays routed while off
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            active_sel <= SEL_DISABLE;
            adc_enable <= 1'b0;
        end else begin
            active_sel <= next_sel;
            adc_enable <= (next_sel != SEL_DISABLE);
        end
    end

    // One-hot multiplexer select, channel 2 first, one per input pin
    genvar g;
    generate
        for (g = 0; g < CH_NUM; g++) begin : g_mux
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mux_select[g] <= 1'b0;
                end else begin
                    mux_select[g] <= (next_sel == SEL_FIRST + SEL_W'(g));
                end
            end
        end
    endgenerate

    // Sticky events, set wins over write-one clear
    always_comb begin
        next_irq_status = irq_status;
        if (wr_irq_sts) begin
            next_irq_status = irq_status & ~hwdata[IRQ_W-1:0];
        end
        if (sar.done) begin
            next_irq_status[IRQ_DONE] = 1'b1;
        end
        if (token_rise) begin
            next_irq_status[IRQ_TOKEN] = 1'b1;
        end
    end

    // Status, mask and interrupt line
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= RST_IRQ;
            irq_mask   <= RST_IRQ;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_irq_msk) begin
                irq_mask <= hwdata[IRQ_W-1:0];
            end
            irq <= |(next_irq_status & (wr_irq_msk ? hwdata[IRQ_W-1:0] : irq_mask));
        end
    end
endmodule
